//--- src/tgs_edge_det.sv
// Purpose: registers a level and flags its rising and falling edges
// Assumes: level input already in the clock domain
// Notes: edges are one-cycle pulses aligned with the level, which is passed through unregistered
`timescale 1ns/10ps
module tgs_edge_det (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic level_in,
	tgs_edge_if.src edge_out
);
	logic prev_reg;
	logic prev_next;

	// next previous level
	always_comb begin
		prev_next = level_in;
	end

	// previous level register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
		end
	end

	// compare previous with current
	assign edge_out.level = level_in;
	assign edge_out.rise = level_in & ~prev_reg;
	assign edge_out.fall = ~level_in & prev_reg;
endmodule : tgs_edge_det

//--- src/tgs_edge_if.sv
// Purpose: carries a level and its one-cycle edge pulses between modules
// Assumes: same clock on both sides
// Notes: produced by the edge detector, consumed by the top
`timescale 1ns/10ps
interface tgs_edge_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : tgs_edge_if

//--- src/tgs_pkg.sv
// Purpose: shared constants and types for the timer gate status block
// Assumes: one 250 MHz system clock, synchronous active-high reset
// Notes: no register bus; control and status bits are plain ports
package tgs_pkg;
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [7:0] T0_MAX = 8'hff;
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_SYS = 2'h1;
	localparam logic [1:0] CS_EXT = 2'h2;
	localparam logic [1:0] CS_LFOSC = 2'h3;
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
	localparam logic FLAG_RST = 1'b0;
	typedef enum logic {
		TGS_SRC_PIN,
		TGS_SRC_T0OVF
	} tgs_src_t;
endpackage : tgs_pkg

//--- src/tgs_top.sv
// Purpose: gate status, gate event flag, rollover flag and wake of a
//   16-bit timer
// Assumes: software clears flags by one-cycle clear pulses
// Notes: the external count clock is sampled, so sleep counting uses
//   the always-running system clock as the timer's own oscillator
`timescale 1ns/10ps
module tgs_top (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic gate_input_pin_in,
	input wire logic ext_count_clock_pin_in,
	input wire logic timer_on_ctl_in,
	input wire logic gate_enable_ctl_in,
	input wire logic gate_polarity_in,
	input wire logic gate_toggle_mode_in,
	input wire logic single_pulse_mode_in,
	input wire logic single_pulse_arm_set_in,
	input wire logic single_pulse_arm_clr_in,
	input wire logic gate_source_sel_in,
	input wire logic sync_bypass_ctl_in,
	input wire logic [1:0] clock_select_field_in,
	input wire logic count_write_in,
	input wire logic [15:0] count_wdata_in,
	input wire logic t0_tick_in,
	input wire logic [7:0] t0_count_in,
	input wire logic sleep_in,
	input wire logic gate_event_irq_en_in,
	input wire logic rollover_irq_en_in,
	input wire logic periph_irq_global_en_in,
	input wire logic global_irq_en_in,
	input wire logic gate_flag_clr_in,
	input wire logic rollover_flag_clr_in,
	output logic gate_level_status_out,
	output logic single_pulse_arm_out,
	output logic gate_event_flag_out,
	output logic rollover_flag_out,
	output logic [7:0] count_high_byte_out,
	output logic [7:0] count_low_byte_out,
	output logic irq_req_out,
	output logic wake_out,
	output logic irq_vector_out
);
	logic gpin_s1_reg, gpin_s2_reg, ck_s1_reg, ck_s2_reg;
	logic ck_prev_reg, ck_prev_next;
	logic [1:0] div_reg, div_next;
	logic [15:0] cnt_reg, cnt_next;
	logic tog_reg, tog_next;
	logic arm_reg, arm_next;
	logic gflag_reg, gflag_next;
	logic rflag_reg, rflag_next;
	logic t0_ovf, gate_src, gate_pol, gate_val, inc_tick, count_en;
	logic running, wrap, gated_ok;
	tgs_edge_if gv_edge ();
	tgs_edge_if gp_edge ();

	// pin synchronisers, second stage only is read
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			gpin_s1_reg <= 1'b0;
			gpin_s2_reg <= 1'b0;
			ck_s1_reg <= 1'b0;
			ck_s2_reg <= 1'b0;
		end else begin
			gpin_s1_reg <= gate_input_pin_in;
			gpin_s2_reg <= gpin_s1_reg;
			ck_s1_reg <= ext_count_clock_pin_in;
			ck_s2_reg <= ck_s1_reg;
		end
	end

	assign t0_ovf = t0_tick_in && (t0_count_in == tgs_pkg::T0_MAX);
	// gate source selection and polarity
	assign gate_src = (gate_source_sel_in == 1'(tgs_pkg::TGS_SRC_T0OVF))
		? t0_ovf : gpin_s2_reg;
	assign gate_pol = gate_src ^ ~gate_polarity_in;

	// increment tick per clock select
	always_comb begin
		div_next = div_reg + 2'h1;
		ck_prev_next = ck_s2_reg;
		unique case (clock_select_field_in)
			tgs_pkg::CS_INSTR: inc_tick = (div_reg == tgs_pkg::INSTR_DIV_LAST);
			tgs_pkg::CS_SYS: inc_tick = 1'b1;
			tgs_pkg::CS_EXT: inc_tick = ck_s2_reg & ~ck_prev_reg;
			tgs_pkg::CS_LFOSC: inc_tick = (div_reg == tgs_pkg::INSTR_DIV_LAST);
		endcase
	end

	// rising edges of the polarity-adjusted gate for toggle
	tgs_edge_det u_gp_edge (
		.clk_in(ref_clk_in),
		.rst_in(sys_rst_in),
		.level_in(gate_pol),
		.edge_out(gp_edge.src)
	);

	// toggle flop, held clear when off
	// flips once per gate rise so a full gate cycle is measured
	always_comb begin
		if (!gate_toggle_mode_in) begin
			tog_next = 1'b0;
		end else if (gp_edge.rise) begin
			tog_next = ~tog_reg;
		end else begin
			tog_next = tog_reg;
		end
	end

	assign gate_val = gate_toggle_mode_in ? tog_reg : gate_pol;
	assign gate_level_status_out = gate_val;

	tgs_edge_det u_gv_edge (
		.clk_in(ref_clk_in),
		.rst_in(sys_rst_in),
		.level_in(gate_val),
		.edge_out(gv_edge.src)
	);

	always_comb begin
		arm_next = arm_reg;
		if (single_pulse_arm_clr_in || !single_pulse_mode_in) begin
			arm_next = 1'b0;
		end else if (gv_edge.fall) begin
			arm_next = 1'b0;
		end else if (single_pulse_arm_set_in) begin
			arm_next = 1'b1;
		end
	end

	assign gated_ok = !single_pulse_mode_in || arm_reg;
	assign count_en = !gate_enable_ctl_in || (gate_val && gated_ok);
	// sleep stops all but async external counting
	assign running = timer_on_ctl_in && count_en && (!sleep_in ||
		(sync_bypass_ctl_in && clock_select_field_in == tgs_pkg::CS_EXT));
	// wrap from all ones to zero
	assign wrap = running && inc_tick && (cnt_reg == tgs_pkg::CNT_MAX);

	// counter next value
	always_comb begin
		if (count_write_in) begin
			cnt_next = count_wdata_in;
		end else if (running && inc_tick) begin
			cnt_next = cnt_reg + 16'h0001;
		end else begin
			cnt_next = cnt_reg;
		end
	end

	always_comb begin
		gflag_next = gflag_reg;
		rflag_next = rflag_reg;
		if (gate_flag_clr_in) begin
			gflag_next = 1'b0;
		end
		if (rollover_flag_clr_in) begin
			rflag_next = 1'b0;
		end
		if (gv_edge.fall) begin
			gflag_next = 1'b1;
		end
		if (wrap) begin
			rflag_next = 1'b1;
		end
	end

	// state registers
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			div_reg <= 2'h0;
			ck_prev_reg <= 1'b0;
			cnt_reg <= tgs_pkg::CNT_RST;
			tog_reg <= 1'b0;
			arm_reg <= 1'b0;
			gflag_reg <= tgs_pkg::FLAG_RST;
			rflag_reg <= tgs_pkg::FLAG_RST;
		end else begin
			div_reg <= div_next;
			ck_prev_reg <= ck_prev_next;
			cnt_reg <= cnt_next;
			tog_reg <= tog_next;
			arm_reg <= arm_next;
			gflag_reg <= gflag_next;
			rflag_reg <= rflag_next;
		end
	end

	assign single_pulse_arm_out = arm_reg;
	assign gate_event_flag_out = gflag_reg;
	assign rollover_flag_out = rflag_reg;
	assign count_high_byte_out = cnt_reg[15:8];
	assign count_low_byte_out = cnt_reg[7:0];

	assign irq_req_out = periph_irq_global_en_in && (
		(gflag_reg && gate_event_irq_en_in) ||
		(rflag_reg && rollover_irq_en_in && timer_on_ctl_in));
	assign wake_out = sleep_in && rflag_reg && rollover_irq_en_in &&
		periph_irq_global_en_in && timer_on_ctl_in;
	assign irq_vector_out = irq_req_out && global_irq_en_in;

	flag_set_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) wrap |=> rflag_reg)
		else $error("rollover flag lost");
	gate_fall_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) gv_edge.fall |=> gflag_reg)
		else $error("gate flag not set on fall");
	wrap_zero_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) wrap && !count_write_in |=> cnt_reg == 16'h0)
		else $error("counter did not wrap to zero");
	gate_hold_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		gate_enable_ctl_in && !gate_val && !count_write_in
		|=> $stable(cnt_reg)) else $error("count moved while gated");
	arm_clear_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) gv_edge.fall |=> !arm_reg)
		else $error("arm not cleared");
	tog_clear_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) !gate_toggle_mode_in |=> !tog_reg)
		else $error("toggle flop not cleared");
	irq_gate_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		irq_req_out && !gflag_reg |-> timer_on_ctl_in && rollover_irq_en_in)
		else $error("rollover irq without enables");
	sleep_stop_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		sleep_in && !sync_bypass_ctl_in && !count_write_in
		|=> $stable(cnt_reg)) else $error("count moved in sleep");
	vec_gate_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in) irq_vector_out |-> global_irq_en_in)
		else $error("vector without global enable");
	// status follows pin two clocks late
	status_live_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		!gate_toggle_mode_in && !gate_source_sel_in &&
		!$past(sys_rst_in) && !$past(sys_rst_in, 2)
		|-> gate_level_status_out ==
		($past(gate_input_pin_in, 2) ^ ~gate_polarity_in))
		else $error("gate status not tracking pin");
	// toggle flop inverts on each gate rise
	tog_flip_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		gate_toggle_mode_in && gp_edge.rise |=> tog_reg != $past(tog_reg))
		else $error("toggle flop did not invert");
	// gate flag with enables raises request
	gate_irq_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		gflag_reg && gate_event_irq_en_in && periph_irq_global_en_in
		|-> irq_req_out) else $error("gate irq request missing");
	// rollover flag with four enables vectors
	roll_vec_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		rflag_reg && timer_on_ctl_in && rollover_irq_en_in &&
		periph_irq_global_en_in && global_irq_en_in |-> irq_vector_out)
		else $error("rollover vector missing");
	// gate flag stays up until cleared
	flag_keep_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		gflag_reg && !gate_flag_clr_in |=> gflag_reg)
		else $error("gate flag dropped without clear");
	// fall seen only after a high level
	fall_detect_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		gv_edge.fall |-> !gate_val && $past(gate_val))
		else $error("false gate fall");
	sequence disarmed_s;
		single_pulse_mode_in && gate_enable_ctl_in && !arm_reg &&
		!count_write_in;
	endsequence
	arm_block_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		disarmed_s |=> $stable(cnt_reg))
		else $error("count moved while disarmed");
	// overflow in sleep with enables wakes
	sequence sleep_wrap_s;
		sleep_in && wrap;
	endsequence
	sequence wake_ready_s;
		sleep_in && timer_on_ctl_in && rollover_irq_en_in &&
		periph_irq_global_en_in;
	endsequence
	sleep_wake_a: assert property (@(posedge ref_clk_in)
		disable iff (sys_rst_in)
		sleep_wrap_s ##1 wake_ready_s |-> wake_out)
		else $error("no wake on sleep overflow");
endmodule : tgs_top

//--- verification/tgs_tb.sv
// Purpose: self-checking bench for the timer gate status block
// Assumes: inputs change on the falling edge, outputs sampled there too
// Notes: one task per scenario, bounded waits only
`timescale 1ns/10ps
module tb;
	logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, gate_input_pin_in = 1'b0;
	logic ext_count_clock_pin_in = 1'b0, timer_on_ctl_in = 1'b0;
	logic gate_enable_ctl_in = 1'b0, gate_polarity_in = 1'b1;
	logic gate_toggle_mode_in = 1'b0, single_pulse_mode_in = 1'b0;
	logic single_pulse_arm_set_in = 1'b0, single_pulse_arm_clr_in = 1'b0;
	logic gate_source_sel_in = 1'b0, sync_bypass_ctl_in = 1'b0;
	logic [1:0] clock_select_field_in = 2'h1;
	logic count_write_in = 1'b0, t0_tick_in = 1'b0, sleep_in = 1'b0;
	logic [15:0] count_wdata_in = 16'h0000;
	logic [7:0] t0_count_in = 8'h00;
	logic gate_event_irq_en_in = 1'b0, rollover_irq_en_in = 1'b0;
	logic periph_irq_global_en_in = 1'b1, global_irq_en_in = 1'b0;
	logic gate_flag_clr_in = 1'b0, rollover_flag_clr_in = 1'b0;
	logic gate_level_status_out, single_pulse_arm_out, gate_event_flag_out;
	logic rollover_flag_out, irq_req_out, wake_out, irq_vector_out;
	logic [7:0] count_high_byte_out, count_low_byte_out;
	int error_cnt = 0, cmp_count = 0;
	wire logic [15:0] cnt = {count_high_byte_out, count_low_byte_out};
	// device under test
	tgs_top uut (.ref_clk_in, .sys_rst_in, .gate_input_pin_in,
		.ext_count_clock_pin_in, .timer_on_ctl_in, .gate_enable_ctl_in,
		.gate_polarity_in, .gate_toggle_mode_in, .single_pulse_mode_in,
		.single_pulse_arm_set_in, .single_pulse_arm_clr_in,
		.gate_source_sel_in, .sync_bypass_ctl_in, .clock_select_field_in,
		.count_write_in, .count_wdata_in, .t0_tick_in, .t0_count_in,
		.sleep_in, .gate_event_irq_en_in, .rollover_irq_en_in,
		.periph_irq_global_en_in, .global_irq_en_in, .gate_flag_clr_in,
		.rollover_flag_clr_in, .gate_level_status_out, .single_pulse_arm_out,
		.gate_event_flag_out, .rollover_flag_out, .count_high_byte_out,
		.count_low_byte_out, .irq_req_out, .wake_out, .irq_vector_out);
	// 250 MHz clock
	always #2 ref_clk_in = ~ref_clk_in;
	task test_done;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	task chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask : cyc
	// bounded wait on one output; running out counts as a mismatch
	task wf(input int s, input logic v);
		int i;
		logic x;
		for (i = 0; i < 64; i++) begin
			@(negedge ref_clk_in);
			case (s)
				0: x = gate_level_status_out;
				1: x = gate_event_flag_out;
				2: x = wake_out;
				default: x = single_pulse_arm_out;
			endcase
			if (x === v) break;
		end
		if (i == 64) begin
			error_cnt++;
			$display("CHECK FAILED %0t wait ran out on %0d", $time, s);
			test_done;
		end
	endtask : wf
	task clr_flags;
		gate_flag_clr_in = 1'b1;
		rollover_flag_clr_in = 1'b1;
		cyc(1);
		gate_flag_clr_in = 1'b0;
		rollover_flag_clr_in = 1'b0;
		cyc(1);
	endtask : clr_flags
	// gate status and gate event flag with the gate disabled
	task t_gate;
		gate_input_pin_in = 1'b1;
		wf(0, 1'b1);
		chk(gate_level_status_out, 1'b1);
		chk(gate_event_flag_out, 1'b0);
		gate_input_pin_in = 1'b0;
		wf(1, 1'b1);
		chk(gate_level_status_out, 1'b0);
		chk(irq_req_out, 1'b0);
		gate_event_irq_en_in = 1'b1;
		cyc(4);
		chk(irq_req_out, 1'b1);
		chk(gate_event_flag_out, 1'b1);
		gate_event_irq_en_in = 1'b0;
		clr_flags;
		chk(gate_event_flag_out, 1'b0);
		$display("t_gate done");
	endtask : t_gate
	// wrap from all ones to zero sets the rollover flag
	task t_roll;
		count_write_in = 1'b1;
		count_wdata_in = 16'hffff;
		cyc(1);
		count_write_in = 1'b0;
		chk(cnt, 16'hffff);
		timer_on_ctl_in = 1'b1;
		rollover_irq_en_in = 1'b1;
		cyc(1);
		timer_on_ctl_in = 1'b0;
		chk(cnt, 16'h0000);
		chk(rollover_flag_out, 1'b1);
		cyc(3);
		chk(rollover_flag_out, 1'b1);
		chk(irq_req_out, 1'b0);
		timer_on_ctl_in = 1'b1;
		global_irq_en_in = 1'b1;
		cyc(1);
		chk(irq_req_out, 1'b1);
		chk(irq_vector_out, 1'b1);
		rollover_irq_en_in = 1'b0;
		cyc(1);
		chk(irq_req_out, 1'b0);
		timer_on_ctl_in = 1'b0;
		global_irq_en_in = 1'b0;
		clr_flags;
		chk(rollover_flag_out, 1'b0);
		$display("t_roll done");
	endtask : t_roll
	// sleep freezes sync count; async ext count wraps and wakes
	task t_sleep;
		count_write_in = 1'b1;
		count_wdata_in = 16'hfffe;
		{sleep_in, timer_on_ctl_in, rollover_irq_en_in} = 3'h7;
		cyc(1);
		count_write_in = 1'b0;
		cyc(10);
		chk(cnt, 16'hfffe);
		chk(wake_out, 1'b0);
		{sleep_in, timer_on_ctl_in} = 2'h0;
		cyc(1);
		// async external source and sleep set up together
		{sync_bypass_ctl_in, timer_on_ctl_in, sleep_in} = 3'h7;
		clock_select_field_in = 2'h2;
		repeat (2) begin
			ext_count_clock_pin_in = 1'b1;
			cyc(4);
			ext_count_clock_pin_in = 1'b0;
			cyc(4);
		end
		wf(2, 1'b1);
		chk(cnt, 16'h0000);
		chk(rollover_flag_out, 1'b1);
		chk(irq_vector_out, 1'b0);
		global_irq_en_in = 1'b1;
		cyc(1);
		chk(irq_vector_out, 1'b1);
		{sleep_in, timer_on_ctl_in, global_irq_en_in} = 3'h0;
		{rollover_irq_en_in, sync_bypass_ctl_in} = 2'h0;
		clock_select_field_in = 2'h1;
		clr_flags;
		$display("t_sleep done");
	endtask : t_sleep
	// gated counting holds while the gate is inactive
	task t_gated;
		gate_enable_ctl_in = 1'b1;
		timer_on_ctl_in = 1'b1;
		cyc(8);
		chk(cnt, 16'h0000);
		gate_input_pin_in = 1'b1;
		cyc(8);
		chk(cnt, 16'h0006);
		gate_input_pin_in = 1'b0;
		{gate_enable_ctl_in, timer_on_ctl_in} = 2'h0;
		cyc(4);
		clr_flags;
		// divided sources tick once per four clocks
		clock_select_field_in = 2'h0;
		timer_on_ctl_in = 1'b1;
		cyc(8);
		chk(cnt, 16'h0008);
		clock_select_field_in = 2'h3;
		cyc(8);
		chk(cnt, 16'h000a);
		timer_on_ctl_in = 1'b0;
		clock_select_field_in = 2'h1;
		$display("t_gated done");
	endtask : t_gated
	// companion wrap pulses the gate; single pulse disarms on fall
	task t_pulse;
		gate_source_sel_in = 1'b1;
		t0_count_in = 8'hff;
		t0_tick_in = 1'b1;
		cyc(1);
		chk(gate_level_status_out, 1'b1);
		t0_tick_in = 1'b0;
		t0_count_in = 8'h00;
		wf(1, 1'b1);
		chk(gate_event_flag_out, 1'b1);
		chk(gate_level_status_out, 1'b0);
		gate_source_sel_in = 1'b0;
		cyc(4);
		clr_flags;
		single_pulse_mode_in = 1'b1;
		gate_enable_ctl_in = 1'b1;
		timer_on_ctl_in = 1'b1;
		single_pulse_arm_set_in = 1'b1;
		cyc(1);
		single_pulse_arm_set_in = 1'b0;
		chk(single_pulse_arm_out, 1'b1);
		gate_input_pin_in = 1'b1;
		wf(0, 1'b1);
		gate_input_pin_in = 1'b0;
		wf(3, 1'b0);
		chk(single_pulse_arm_out, 1'b0);
		chk(cnt, 16'h000c);
		gate_input_pin_in = 1'b1;
		cyc(8);
		chk(cnt, 16'h000c);
		{gate_input_pin_in, timer_on_ctl_in} = 2'h0;
		{single_pulse_mode_in, gate_enable_ctl_in} = 2'h0;
		cyc(4);
		clr_flags;
		$display("t_pulse done");
	endtask : t_pulse
	// toggle flop and gate polarity, gate disabled
	task t_toggle;
		gate_toggle_mode_in = 1'b1;
		gate_input_pin_in = 1'b1;
		wf(0, 1'b1);
		chk(gate_event_flag_out, 1'b0);
		gate_input_pin_in = 1'b0;
		cyc(4);
		chk(gate_level_status_out, 1'b1);
		gate_input_pin_in = 1'b1;
		wf(1, 1'b1);
		chk(gate_level_status_out, 1'b0);
		gate_toggle_mode_in = 1'b0;
		cyc(1);
		chk(gate_level_status_out, 1'b1);
		gate_polarity_in = 1'b0;
		cyc(1);
		chk(gate_level_status_out, 1'b0);
		gate_input_pin_in = 1'b0;
		wf(0, 1'b1);
		chk(gate_level_status_out, 1'b1);
		gate_polarity_in = 1'b1;
		cyc(2);
		clr_flags;
		$display("t_toggle done");
	endtask : t_toggle
	// main sequence
	initial begin
		cyc(16);
		sys_rst_in = 1'b0;
		cyc(2);
		chk(cnt, 16'h0000);
		t_gate;
		t_roll;
		t_sleep;
		t_gated;
		t_pulse;
		t_toggle;
		test_done;
	end
endmodule : tb
